/* File: verilog/rtci_regs.sv */
// Added by the designer: strobed register access.
`include "rtci_consts.svh"

module rtci_regs
  import rtci_pkg::*;
#(
  parameter int UPDATE_CYCLES = `RTCI_UPDATE_CYCLES
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic soft_reset_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic active_in,
  input wire logic [15:0] command_word_in,
  input wire logic [15:0] control_word_addr_in,
  input wire logic index_zero_evt_in,
  input wire logic index_zero_allow_in,
  input wire logic accessed_evt_in,
  input wire logic accessed_allow_in,
  input wire logic broadcast_evt_in,
  input wire logic broadcast_allow_in,
  input wire logic message_error_evt_in,
  input wire logic illegal_command_evt_in,
  input wire logic [7:0] hw_evt_in,
  output logic [15:0] descriptor_table_base_out,
  output logic message_irq_out,
  output logic hardware_irq_out,
  output logic log_write_out,
  output logic [15:0] log_entry_out
);

  localparam int UPD = UPDATE_CYCLES;

  rtci_state_t state;
  rtci_state_t next_state;
  logic active_rise;
  logic commit;
  rtci_word_t raw_events;
  rtci_word_t gated_events;
  rtci_word_t pend_after_read;
  logic rd_pend;

  assign active_rise = active_in && !state.active_prev;
  assign rd_pend = reg_rd_in && (reg_addr_in == `RTCI_IDX_PEND);

  // Times the wait from transaction start to register update
  rtci_delay #(
    .CYCLES(UPDATE_CYCLES)
  ) u_update_delay (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .start_in(active_rise),
    .done_out(commit)
  );

  // Event vector in pending layout, unused bits stay zero
  always_comb
  begin
    raw_events = `RTCI_ZERO16;
    raw_events[`RTCI_BIT_IXZ] = index_zero_evt_in && index_zero_allow_in;
    raw_events[`RTCI_BIT_ACC] = accessed_evt_in && accessed_allow_in;
    raw_events[`RTCI_BIT_BRX] = broadcast_evt_in && broadcast_allow_in;
    raw_events[`RTCI_BIT_MESSAGE_ERROR_IRQ] = message_error_evt_in;
    raw_events[`RTCI_BIT_ILLEGAL_COMMAND_IRQ] = illegal_command_evt_in;
    raw_events[`RTCI_HW_HI:`RTCI_HW_LO] = hw_evt_in;
  end

  assign gated_events = raw_events & state.interrupt_enable;

  always_comb
  begin
    next_state = state;
    next_state.active_prev = active_in;
    next_state.log_write = 1'b0;
    next_state.log_entry = state.log_entry;
    if (active_rise)
    begin
      next_state.staged_command = command_word_in;
      next_state.staged_pointer = control_word_addr_in;
    end
    if (commit)
    begin
      next_state.captured_command_word = state.staged_command;
      next_state.control_word_pointer = state.staged_pointer;
    end
    if (reg_wr_in && (reg_addr_in == `RTCI_IDX_BASE))
    begin
      next_state.descriptor_table_base = reg_wdata_in & `RTCI_BASE_MASK;
    end
    if (reg_wr_in && (reg_addr_in == `RTCI_IDX_ENABLE))
    begin
      next_state.interrupt_enable = reg_wdata_in & ~`RTCI_PEND_UNUSED_MASK;
    end
    // Soft reset touches only the base register
    if (soft_reset_in)
    begin
      next_state.descriptor_table_base = `RTCI_BASE_RESET;
    end
    // A new event in the read cycle survives the clear
    pend_after_read = rd_pend ? `RTCI_ZERO16 : state.pending_interrupts;
    next_state.pending_interrupts = (pend_after_read | gated_events) & ~`RTCI_PEND_UNUSED_MASK;
    if (gated_events != `RTCI_ZERO16)
    begin
      next_state.log_write = 1'b1;
      next_state.log_entry = gated_events;
    end
    next_state.message_irq = |(next_state.pending_interrupts & next_state.interrupt_enable & `RTCI_PEND_MSG_MASK);
    next_state.hardware_irq = |(next_state.pending_interrupts & next_state.interrupt_enable & `RTCI_PEND_HW_MASK);
    next_state.rd_data = `RTCI_ZERO16;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        `RTCI_IDX_CMD: next_state.rd_data = state.captured_command_word;
        `RTCI_IDX_PTR: next_state.rd_data = state.control_word_pointer;
        `RTCI_IDX_BASE: next_state.rd_data = state.descriptor_table_base;
        `RTCI_IDX_PEND: next_state.rd_data = state.pending_interrupts;
        `RTCI_IDX_ENABLE: next_state.rd_data = state.interrupt_enable;
        default: next_state.rd_data = `RTCI_ZERO16;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state <= '0;
      state.descriptor_table_base <= `RTCI_BASE_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign reg_rdata_out = state.rd_data;
  assign descriptor_table_base_out = state.descriptor_table_base;
  assign message_irq_out = state.message_irq;
  assign hardware_irq_out = state.hardware_irq;
  assign log_write_out = state.log_write;
  assign log_entry_out = state.log_entry;

  // Cycles since the last transaction start, for checking only
  logic [15:0] since_rise;
  logic seen_rise;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      since_rise <= 16'h0000;
      seen_rise <= 1'b0;
    end
    else if (active_rise)
    begin
      since_rise <= 16'h0000;
      seen_rise <= 1'b1;
    end
    else if (since_rise != 16'hFFFF)
    begin
      since_rise <= since_rise + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  AST_UPDATE_AT_5US: assert property (
    commit |-> (seen_rise && (since_rise == 16'(UPD - 2)) && !active_rise))
    else $error("command update not at the set delay after active");

  AST_CMD_CAPTURE: assert property (
    active_rise ##1 (!active_rise)[*2] |->
      ##[0:UPD] (state.captured_command_word == $past(state.staged_command)) || active_rise)
    else $error("captured command does not match the word at active");

  AST_CMD_HOLD: assert property (
    !$past(commit) |-> $stable(state.captured_command_word) && $stable(state.control_word_pointer))
    else $error("command or pointer changed without an update");

  AST_PTR_VALUE: assert property (
    commit |=> state.control_word_pointer == $past(state.staged_pointer))
    else $error("control word pointer not loaded from staged address");

  AST_BASE_SOFT: assert property (
    soft_reset_in |=> descriptor_table_base_out == `RTCI_BASE_RESET)
    else $error("soft reset did not reload descriptor base");

  AST_BASE_WRITE: assert property (
    reg_wr_in && (reg_addr_in == `RTCI_IDX_BASE) && !soft_reset_in |=>
      descriptor_table_base_out == ($past(reg_wdata_in) & `RTCI_BASE_MASK))
    else $error("descriptor base write not masked correctly");

  AST_READ_CLEARS: assert property (
    rd_pend && (gated_events == `RTCI_ZERO16) |=>
      (state.pending_interrupts == `RTCI_ZERO16) && (reg_rdata_out == $past(state.pending_interrupts)))
    else $error("pending read did not return and clear");

  AST_NO_SET_DISABLED: assert property (
    ##1 ((state.pending_interrupts & ~$past(state.pending_interrupts) & ~$past(state.interrupt_enable))
      == `RTCI_ZERO16))
    else $error("pending bit set while disabled");

  AST_SET_AND_LOG: assert property (
    gated_events != `RTCI_ZERO16 |=>
      ((state.pending_interrupts & $past(gated_events)) == $past(gated_events)) && log_write_out &&
      (log_entry_out == $past(gated_events)))
    else $error("enabled event not pended or logged");

  AST_IXZ_MSG: assert property (
    index_zero_evt_in && index_zero_allow_in && state.interrupt_enable[`RTCI_BIT_IXZ] && !reg_wr_in |=>
      state.pending_interrupts[`RTCI_BIT_IXZ] && message_irq_out)
    else $error("index zero event did not raise message interrupt");

  AST_ILLEGAL_COMMAND_IRQ_MSG: assert property (
    illegal_command_evt_in && state.interrupt_enable[`RTCI_BIT_ILLEGAL_COMMAND_IRQ] && !reg_wr_in |=>
      message_irq_out && log_write_out)
    else $error("illegal command did not raise message interrupt");

  AST_MESSAGE_ERROR_IRQ_MSG: assert property (
    message_error_evt_in && state.interrupt_enable[`RTCI_BIT_MESSAGE_ERROR_IRQ] && !reg_wr_in |=>
      message_irq_out && log_entry_out[`RTCI_BIT_MESSAGE_ERROR_IRQ])
    else $error("message error did not raise message interrupt");

  AST_HW_OUT: assert property (
    ((gated_events & `RTCI_PEND_HW_MASK) != `RTCI_ZERO16) && !reg_wr_in |=>
      hardware_irq_out && log_write_out)
    else $error("hardware event did not raise hardware interrupt");

  AST_UNUSED_ZERO: assert property (
    (state.pending_interrupts & `RTCI_PEND_UNUSED_MASK) == `RTCI_ZERO16)
    else $error("unused pending bit set");

  COV_UPDATE: cover property (active_rise ##[1:UPD] commit);
  COV_READ_PENDING: cover property (rd_pend && (state.pending_interrupts != `RTCI_ZERO16));
  COV_SET_ON_CLEAR: cover property (rd_pend && (gated_events != `RTCI_ZERO16));
  COV_SOFT_RESET: cover property (soft_reset_in && (descriptor_table_base_out != `RTCI_BASE_RESET));

endmodule : rtci_regs

/* File: verilog/rtci_consts.svh */
`ifndef RTCI_CONSTS_SVH
`define RTCI_CONSTS_SVH

// Register indices on the host port
`define RTCI_IDX_CMD 4'h3
`define RTCI_IDX_PTR 4'h4
`define RTCI_IDX_BASE 4'h5
`define RTCI_IDX_PEND 4'h6
`define RTCI_IDX_ENABLE 4'hF

`define RTCI_ZERO16 16'h0000
`define RTCI_BASE_RESET 16'h0200
`define RTCI_BASE_MASK 16'h7E00

// Pending register layout
`define RTCI_PEND_MSG_MASK 16'hE500
`define RTCI_PEND_HW_MASK 16'h00FF
`define RTCI_PEND_UNUSED_MASK 16'h1A00
`define RTCI_BIT_IXZ 15
`define RTCI_BIT_ACC 14
`define RTCI_BIT_BRX 13
`define RTCI_BIT_MESSAGE_ERROR_IRQ 10
`define RTCI_BIT_ILLEGAL_COMMAND_IRQ 8
`define RTCI_HW_HI 7
`define RTCI_HW_LO 0

// Timing
`define RTCI_CLK_PERIOD_NS 25
`define RTCI_UPDATE_DELAY_NS 5000
`define RTCI_UPDATE_CYCLES ((`RTCI_UPDATE_DELAY_NS + `RTCI_CLK_PERIOD_NS - 1) / `RTCI_CLK_PERIOD_NS)

`endif

/* File: verilog/rtci_pkg.sv */
package rtci_pkg;

  typedef logic [15:0] rtci_word_t;

  typedef struct packed {
    rtci_word_t captured_command_word;
    rtci_word_t control_word_pointer;
    rtci_word_t descriptor_table_base;
    rtci_word_t pending_interrupts;
    rtci_word_t interrupt_enable;
    rtci_word_t staged_command;
    rtci_word_t staged_pointer;
    logic active_prev;
    rtci_word_t rd_data;
    logic message_irq;
    logic hardware_irq;
    logic log_write;
    rtci_word_t log_entry;
  } rtci_state_t;

endpackage : rtci_pkg

/* File: verilog/rtci_delay.sv */
`include "rtci_consts.svh"

module rtci_delay
  import rtci_pkg::*;
#(
  parameter int CYCLES = `RTCI_UPDATE_CYCLES
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic start_in,
  output logic done_out
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
  } rtci_delay_state_t;

  rtci_delay_state_t state;
  rtci_delay_state_t next_state;

  // Restart discards a wait already running
  always_comb
  begin
    next_state = state;
    if (start_in)
    begin
      next_state.count = CW'(CYCLES - 1);
    end
    else if (state.count != '0)
    begin
      next_state.count = state.count - CW'(1);
    end
  end

  assign done_out = (state.count == CW'(1)) && !start_in;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

endmodule : rtci_delay

/* File: sim/rtci_host.sv */
module rtci_host
  import rtci_pkg::*;
(
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic [3:0] addr_out,
  output logic [15:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    addr_out = 4'h0;
    wdata_out = 16'h0000;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask : wr
  // Data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1 d = rdata_in;
  endtask : rd
endmodule : rtci_host

/* File: sim/rt_command_and_irq_regs_tb.sv */
`include "rtci_consts.svh"
module rt_command_and_irq_regs_tb
  import rtci_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int UC = 4;
  logic clk_in, reset_n_in, soft_reset_in, active_in, allow;
  logic [15:0] cmd_w, ptr_w, ev, d, rdata, wdata, base_o, log_e;
  logic [3:0] addr;
  logic wr, rd, msg_o, hw_o, log_w;
  int fails, tests_run, i, a, w, x, en, hit;

  rtci_host rtci_host_i (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));
  rtci_regs #(.UPDATE_CYCLES(UC)) rtci_regs_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .soft_reset_in(soft_reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .active_in(active_in), .command_word_in(cmd_w),
    .control_word_addr_in(ptr_w), .index_zero_evt_in(ev[15]), .index_zero_allow_in(allow),
    .accessed_evt_in(ev[14]), .accessed_allow_in(allow), .broadcast_evt_in(ev[13]),
    .broadcast_allow_in(allow), .message_error_evt_in(ev[10]), .illegal_command_evt_in(ev[8]),
    .hw_evt_in(ev[7:0]), .descriptor_table_base_out(base_o), .message_irq_out(msg_o),
    .hardware_irq_out(hw_o), .log_write_out(log_w), .log_entry_out(log_e));

  task automatic chk(input rtci_word_t got, input rtci_word_t exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [3:0] ra, input int exp);
    rtci_host_i.rd(ra, d);
    chk(d, exp[15:0]);
  endtask : rdc

  task automatic results;
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  initial
  begin
    #1000000;
    fails++;
    results();
  end

  initial
  begin
    reset_n_in = 1'b0;
    soft_reset_in = 1'b0;
    active_in = 1'b0;
    allow = 1'b0;
    cmd_w = 16'h0000;
    ptr_w = 16'h0000;
    ev = 16'h0000;
    w = $urandom(32'hA75D);
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rdc(`RTCI_IDX_CMD, 0);
    rdc(`RTCI_IDX_PTR, 0);
    rdc(`RTCI_IDX_BASE, 'h0200);
    rdc(`RTCI_IDX_PEND, 0);
    rdc(4'h0, 0);
    @(posedge clk_in);
    #1 chk(rdata, 16'h0000);
    rtci_host_i.wr(`RTCI_IDX_BASE, 16'h0400);
    #1 chk(base_o, 16'h0400);
    repeat (4)
    begin
      w = $urandom | 'h0200;
      rtci_host_i.wr(`RTCI_IDX_BASE, w[15:0]);
      rdc(`RTCI_IDX_BASE, w & `RTCI_BASE_MASK);
    end
    // Capture, inputs changed after the rise
    w = $urandom & 'hFFFF;
    x = $urandom & 'hFFFF;
    @(posedge clk_in);
    active_in <= 1'b1;
    cmd_w <= w[15:0];
    ptr_w <= x[15:0];
    rdc(`RTCI_IDX_CMD, 0);
    cmd_w <= ~w[15:0];
    ptr_w <= ~x[15:0];
    repeat (UC) @(posedge clk_in);
    rdc(`RTCI_IDX_CMD, w);
    rdc(`RTCI_IDX_PTR, x);
    active_in <= 1'b0;
    // Random enables and permissions per event
    for (int k = 0; k < 48; k++)
    begin
      i = k % 16;
      if (((`RTCI_PEND_UNUSED_MASK >> i) & 1) != 0)
        continue;
      en = $urandom & 'hFFFF;
      a = $urandom % 2;
      rtci_host_i.wr(`RTCI_IDX_ENABLE, en[15:0]);
      rdc(`RTCI_IDX_ENABLE, en & ~`RTCI_PEND_UNUSED_MASK);
      @(posedge clk_in);
      ev <= 16'h0001 << i;
      allow <= a[0];
      @(posedge clk_in);
      ev <= 16'h0000;
      hit = ((en >> i) & 1) != 0 && (i < 13 || a != 0);
      #1 chk(log_w, hit);
      chk(msg_o, hit & (`RTCI_PEND_MSG_MASK >> i));
      chk(hw_o, hit & (i < 8));
      if (hit != 0)
        chk(log_e, 16'h0001 << i);
      rdc(`RTCI_IDX_PEND, hit << i);
      rdc(`RTCI_IDX_PEND, 0);
      chk({msg_o, hw_o}, 0);
    end
    // All events at once, then soft reset
    rtci_host_i.wr(`RTCI_IDX_ENABLE, 16'hFFFF);
    @(posedge clk_in);
    ev <= 16'hFFFF;
    allow <= 1'b1;
    @(posedge clk_in);
    ev <= 16'h0000;
    rtci_host_i.wr(`RTCI_IDX_BASE, 16'h0600);
    @(posedge clk_in);
    soft_reset_in <= 1'b1;
    @(posedge clk_in);
    soft_reset_in <= 1'b0;
    rdc(`RTCI_IDX_BASE, 'h0200);
    rdc(`RTCI_IDX_CMD, w);
    rdc(`RTCI_IDX_PTR, x);
    rdc(`RTCI_IDX_PEND, 'hE5FF);
    results();
  end
endmodule : rt_command_and_irq_regs_tb
